// ===== rtl/twu_pkg.sv
// Shared constants, register map and types of the two-wire host unit.
package twu_pkg;

  // Clock period of MCLK in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Base inactive-bus time-out in nanoseconds, doubled by each selector step.
  localparam int unsigned TOUT_BASE_NS = 50000;
  // Base time-out as a count of MCLK cycles.
  localparam int unsigned TOUT_BASE_CYC = TOUT_BASE_NS / CLK_PERIOD_NS;

  // Register indices on the plain register port.
  localparam logic [2:0] REG_CTRL_A = 3'h0;
  localparam logic [2:0] REG_CTRL_B = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_RATE = 3'h3;
  localparam logic [2:0] REG_TARGET = 3'h4;
  localparam logic [2:0] REG_BYTE = 3'h5;

  // Field positions in host_ctrl_a_reg.
  localparam int unsigned CA_EN_BIT = 0;
  localparam int unsigned CA_TOUT_LSB = 2;
  // Field positions in host_ctrl_b_reg.
  localparam int unsigned CB_CMD_LSB = 0;
  localparam int unsigned CB_ACKACT_BIT = 2;
  // Field positions in host_status_reg.
  localparam int unsigned ST_RIF_BIT = 7;
  localparam int unsigned ST_WIF_BIT = 6;
  localparam int unsigned ST_HOLD_BIT = 5;
  localparam int unsigned ST_ACK_BIT = 4;
  localparam int unsigned ST_ARB_BIT = 3;
  localparam int unsigned ST_BERR_BIT = 2;
  localparam int unsigned ST_LS_LSB = 0;

  // Reset values of the rate, target and byte registers.
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Encoding of line_state_field.
  localparam logic [1:0] LS_UNKNOWN = 2'h0;
  localparam logic [1:0] LS_IDLE = 2'h1;
  localparam logic [1:0] LS_OWNER = 2'h2;
  localparam logic [1:0] LS_BUSY = 2'h3;

  // Encoding of host_cmd_field.
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_REPSTART = 2'h1;
  localparam logic [1:0] CMD_BYTE = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;

  // Extra cycles added to the rate divisor for the low and high halves of SCL.
  localparam logic [8:0] LOW_EXTRA = 9'h006;
  localparam logic [8:0] HIGH_EXTRA = 9'h004;
  // Index of the acknowledge bit within a nine-bit packet.
  localparam logic [3:0] ACK_BITN = 4'h8;
  // Index of the last data bit of a received byte.
  localparam logic [3:0] LAST_BITN = 4'h7;

  // Host engine states.
  typedef enum logic [3:0] {
    E_IDLE, E_WAIT, E_START, E_LOW, E_HIGH, E_HOLD, E_RSL, E_RSH, E_PL, E_PH, E_PS
  } twu_eng_t;

endpackage

// ===== rtl/twu_mon_if.sv
// Signals between the host engine and the bus state monitor.
`timescale 1ns/1ps
interface twu_mon_if;
  logic en; // Host enabled.
  logic scl; // Synchronised SCL level.
  logic sda; // Synchronised SDA level.
  logic own_start; // Engine is generating a Start.
  logic collide; // Arbitration lost or bus error pulse.
  logic force_idle; // Software forces Idle.
  logic [1:0] tsel; // Time-out selector.
  logic [1:0] state; // Bus state.
  logic start_det; // Start condition seen.
  logic stop_det; // Stop condition seen.

  modport eng (output en, scl, sda, own_start, collide, force_idle, tsel, input state, start_det, stop_det);
  modport mon (input en, scl, sda, own_start, collide, force_idle, tsel, output state, start_det, stop_det);
endinterface

// ===== rtl/twu_bus_monitor.sv
// Bus state tracker: Start/Stop detection, inactivity time-out and state.
`timescale 1ns/1ps
module twu_bus_monitor import twu_pkg::*; #(
  parameter int unsigned TOUT_CYC = TOUT_BASE_CYC // Base time-out in cycles.
) (
  input wire logic clk, // Peripheral clock.
  input wire logic rst_n, // Synchronous reset, active low.
  twu_mon_if.mon mon // Link to the engine.
);

  // All monitor state in one record.
  typedef struct packed {
    logic [1:0] st;
    logic scl_p;
    logic sda_p;
    logic [17:0] tcnt;
  } twu_mon_st_t;

  twu_mon_st_t q, n;
  logic tout; // Inactivity time-out reached.
  logic [17:0] lim; // Selected time-out length.

  // Edges are judged on already synchronised levels, so no metastable sample reaches them.
  assign mon.start_det = mon.scl && q.scl_p && q.sda_p && !mon.sda;
  assign mon.stop_det = mon.scl && q.scl_p && !q.sda_p && mon.sda;
  assign mon.state = q.st;

  // Time-out length doubles for each selector step.
  always_comb begin
    unique case (mon.tsel)
      2'h1: lim = 18'(TOUT_CYC);
      2'h2: lim = 18'(TOUT_CYC * 2);
      default: lim = 18'(TOUT_CYC * 4);
    endcase
  end

  assign tout = (mon.tsel != 2'h0) && (q.tcnt >= lim);

  // Next-state logic of the tracker.
  always_comb begin
    n = q;
    n.scl_p = mon.scl;
    n.sda_p = mon.sda;
    // Only a quiet bus with both lines high counts toward the time-out.
    if (mon.scl && mon.sda && mon.en) begin
      if (q.tcnt != 18'h3ffff) begin
        n.tcnt = q.tcnt + 18'h00001;
      end
    end else begin
      n.tcnt = 18'h00000;
    end
    if (!mon.en) begin
      n.st = LS_UNKNOWN;
    end else if (mon.force_idle) begin
      n.st = LS_IDLE;
    end else begin
      unique case (q.st)
        LS_UNKNOWN: begin
          if (mon.stop_det || tout) begin
            n.st = LS_IDLE;
          end
        end
        LS_IDLE: begin
          if (mon.start_det) begin
            n.st = mon.own_start ? LS_OWNER : LS_BUSY;
          end
        end
        LS_OWNER: begin
          if (mon.stop_det) begin
            n.st = LS_IDLE;
          end else if (mon.collide) begin
            n.st = LS_BUSY;
          end
        end
        LS_BUSY: begin
          if (mon.stop_det || tout) begin
            n.st = LS_IDLE;
          end
        end
      endcase
    end
    // Restart the time-out once it has acted so it fires again only after fresh quiet.
    if (tout && (q.st == LS_UNKNOWN || q.st == LS_BUSY)) begin
      n.tcnt = 18'h00000;
    end
  end

  // Register the record.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '{st: LS_UNKNOWN, scl_p: 1'b1, sda_p: 1'b1, tcnt: 18'h00000};
    end else begin
      q <= n;
    end
  end

endmodule

// ===== rtl/twu_host_top.sv
// Two-wire host engine with register port, SCL generator and address phase.
//
// Overview of operation
// - Either interrupt flag set holds SCL low, except after lost arbitration.
// - Separate write/read flags plus status indicators.
// - SCL period is ten plus twice divisor.
// - High count starts only once SCL high.
// - Low period is divisor plus six cycles.
// - Bus tracker runs whenever host enabled.
// - State Unknown after reset, enable, disable.
// - Writing one forces Idle, nothing else.
// - First Stop moves Unknown to Idle.
// - Nonzero time-out expiry moves to Idle.
// - External Start makes Busy; Stop ends it.
// - Own Start makes Owner; Stop gives Idle.
// - Collision in Owner gives Busy until Stop.
// - Target write starts transaction, copies byte register.
// - Busy bus delays Start until Idle.
// - Write address acked: flag, ack zero, hold.
// - Read address acked: ack zero, receive at once.
// - Address not acked: flag, ack one, hold.
// - Arbitration lost: flags, release lines, go idle.
// - Bus error also sets the fault flag.
// - Received byte sets read flag and holds.
`timescale 1ns/1ps
module twu_host_top import twu_pkg::*; #(
  parameter int unsigned TOUT_CYC = TOUT_BASE_CYC // Base inactivity time-out in cycles.
) (
  input wire logic MCLK, // Peripheral clock, 200 MHz.
  input wire logic RESET_N, // Synchronous reset, active low.
  input wire logic [2:0] ADDR, // Register index.
  input wire logic [7:0] WDATA, // Write data.
  input wire logic WR_STB, // Write strobe.
  input wire logic RD_STB, // Read strobe.
  output logic [7:0] RDATA, // Read data, one cycle after the strobe.
  input wire logic SCL_IN, // SCL pin level.
  output logic SCL_OUT, // SCL drive value, always low.
  output logic SCL_OE_N, // SCL pull-down enable, active low.
  input wire logic SDA_IN, // SDA pin level.
  output logic SDA_OUT, // SDA drive value, always low.
  output logic SDA_OE_N // SDA pull-down enable, active low.
);

  // All host state in one record.
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic en;
    logic [1:0] tsel;
    logic ackact;
    logic [7:0] baud;
    logic [7:0] target;
    logic [7:0] byte_r;
    logic write_done_flag;
    logic read_done_flag;
    logic ack;
    logic arb;
    logic berr;
    twu_eng_t eng;
    logic [8:0] cnt;
    logic [3:0] bitn;
    logic rxmode;
    logic addr_ph;
    logic [1:0] act;
    logic scl_low;
    logic sda_low;
    logic [7:0] rdata;
  } twu_host_st_t;

  twu_host_st_t q, n;
  twu_mon_if mon_if();
  logic collide; // Arbitration lost or bus error this cycle.
  logic force_idle; // Software write of Idle to the state field.
  logic smp; // Sampled SDA at the end of a high phase.
  logic wr_hit_tgt; // Write to host_target_reg.

  // length of one half from the divisor
  // Cycles of one SCL half, counted down to zero.
  function automatic logic [8:0] phase_len(input logic [7:0] b, input logic [8:0] extra);
    phase_len = {1'b0, b} + extra - 9'h001;
  endfunction

  // Level driven on SDA during the low half of a bit: one means pull low.
  function automatic logic drive_bit(input logic rx, input logic [3:0] bn, input logic b7, input logic aa);
    if (bn == ACK_BITN) begin
      drive_bit = rx ? !aa : 1'b0;
    end else begin
      drive_bit = rx ? 1'b0 : !b7;
    end
  endfunction

  twu_bus_monitor #(.TOUT_CYC(TOUT_CYC)) u_mon (
    .clk(MCLK),
    .rst_n(RESET_N),
    .mon(mon_if.mon)
  );

  // Engine side of the monitor link.
  assign mon_if.en = q.en;
  assign mon_if.scl = q.scl_s2;
  assign mon_if.sda = q.sda_s2;
  assign mon_if.own_start = (q.eng == E_START);
  assign mon_if.collide = collide;
  assign mon_if.force_idle = force_idle;
  assign mon_if.tsel = q.tsel;

  // Open-drain pins: only ever pull low, never drive high.
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE_N = !q.scl_low;
  assign SDA_OE_N = !q.sda_low;
  assign RDATA = q.rdata;
  assign smp = q.sda_s2;
  assign wr_hit_tgt = WR_STB && (ADDR == REG_TARGET);

  // Next-state logic: pins, register writes, then the engine sequence.
  always_comb begin
    n = q;
    collide = 1'b0;
    force_idle = 1'b0;
    // Two flops on each pin before any logic looks at the level.
    n.scl_s1 = SCL_IN;
    n.scl_s2 = q.scl_s1;
    n.sda_s1 = SDA_IN;
    n.sda_s2 = q.sda_s1;

    // Plain configuration writes.
    if (WR_STB) begin
      unique case (ADDR)
        REG_CTRL_A: begin
          n.en = WDATA[CA_EN_BIT];
          n.tsel = WDATA[CA_TOUT_LSB +: 2];
        end
        REG_CTRL_B: n.ackact = WDATA[CB_ACKACT_BIT];
        REG_RATE: n.baud = WDATA;
        REG_TARGET: n.target = WDATA;
        REG_STATUS: begin
          // Flags clear by writing one; hardware sets below still win.
          if (WDATA[ST_WIF_BIT]) n.write_done_flag = 1'b0;
          if (WDATA[ST_RIF_BIT]) n.read_done_flag = 1'b0;
          if (WDATA[ST_ARB_BIT]) n.arb = 1'b0;
          if (WDATA[ST_BERR_BIT]) n.berr = 1'b0;
          force_idle = q.en && (WDATA[ST_LS_LSB +: 2] == LS_IDLE);
        end
        default: begin
          // Unmapped or handled by the engine below.
        end
      endcase
    end

    // Engine sequence from the current state.
    unique case (q.eng)
      E_IDLE: begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
        n.cnt = 9'h000;
      end
      E_WAIT: begin
        if (q.cnt != 9'h000) begin
          // Finish the bus free time after our own Stop first.
          n.cnt = q.cnt - 9'h001;
        end else if (mon_if.state == LS_IDLE && q.scl_s2 && q.sda_s2) begin
          n.eng = E_START;
          n.sda_low = 1'b1;
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end
      end
      E_START: begin
        // Start: SDA falls while SCL stays high, then the first low half.
        if (q.cnt == 9'h000) begin
          n.eng = E_LOW;
          n.scl_low = 1'b1;
          n.bitn = 4'h0;
          n.rxmode = 1'b0;
          n.addr_ph = 1'b1;
          n.cnt = phase_len(q.baud, LOW_EXTRA);
        end else begin
          n.cnt = q.cnt - 9'h001;
        end
      end
      E_LOW: begin
        n.scl_low = 1'b1;
        n.sda_low = drive_bit(q.rxmode, q.bitn, q.byte_r[7], q.ackact);
        if (q.cnt == 9'h000) begin
          n.eng = E_HIGH;
          n.scl_low = 1'b0;
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end else begin
          n.cnt = q.cnt - 9'h001;
        end
      end
      E_HIGH: begin
        if (!q.scl_s2) begin
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end else if (q.cnt != 9'h000) begin
          n.cnt = q.cnt - 9'h001;
        end else if (!q.rxmode && q.bitn != ACK_BITN && !q.sda_low && !smp) begin
          collide = 1'b1;
          n.write_done_flag = 1'b1;
          n.arb = 1'b1;
          n.eng = E_IDLE;
          n.sda_low = 1'b0;
        end else begin
          n.eng = E_LOW;
          n.scl_low = 1'b1;
          n.cnt = phase_len(q.baud, LOW_EXTRA);
          if (!q.rxmode) begin
            if (q.bitn != ACK_BITN) begin
              n.byte_r = {q.byte_r[6:0], 1'b0};
              n.bitn = q.bitn + 4'h1;
            end else if (q.addr_ph && q.target[0] && !smp) begin
              n.ack = 1'b0;
              n.rxmode = 1'b1;
              n.addr_ph = 1'b0;
              n.bitn = 4'h0;
            end else begin
              n.ack = smp;
              n.write_done_flag = 1'b1;
              n.addr_ph = 1'b0;
              n.eng = E_HOLD;
            end
          end else if (q.bitn == ACK_BITN) begin
            // Acknowledge sent; carry out the command that asked for it.
            unique case (q.act)
              CMD_STOP: n.eng = E_PL;
              CMD_REPSTART: n.eng = E_RSL;
              default: n.bitn = 4'h0;
            endcase
          end else begin
            n.byte_r = {q.byte_r[6:0], smp};
            n.bitn = q.bitn + 4'h1;
            if (q.bitn == LAST_BITN) begin
              n.read_done_flag = 1'b1;
              n.eng = E_HOLD;
            end
          end
        end
      end
      E_HOLD: begin
        // Released SDA while software decides; SCL low set below while either done flag is set.
        n.sda_low = 1'b0;
      end
      E_RSL, E_PL: begin
        // Low half before a repeated Start or a Stop.
        n.scl_low = 1'b1;
        // SDA moves a cycle after SCL falls, so the edge can never read as Start or Stop.
        n.sda_low = (q.eng == E_PL);
        if (q.cnt == 9'h000) begin
          n.eng = (q.eng == E_RSL) ? E_RSH : E_PH;
          n.scl_low = 1'b0;
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end else begin
          n.cnt = q.cnt - 9'h001;
        end
      end
      E_RSH, E_PH: begin
        // High half, started only once SCL is really high.
        if (!q.scl_s2) begin
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end else if (q.cnt != 9'h000) begin
          n.cnt = q.cnt - 9'h001;
        end else if (q.eng == E_RSH) begin
          n.eng = E_START;
          n.sda_low = 1'b1;
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end else begin
          n.eng = E_PS;
          n.sda_low = 1'b0;
          n.cnt = phase_len(q.baud, HIGH_EXTRA);
        end
      end
      E_PS: begin
        // Bus free time after the Stop.
        if (q.cnt == 9'h000) begin
          n.eng = E_IDLE;
        end else begin
          n.cnt = q.cnt - 9'h001;
        end
      end
    endcase

    if ((q.eng == E_LOW || q.eng == E_HIGH) && (mon_if.start_det || mon_if.stop_det)) begin
      collide = 1'b1;
      n.write_done_flag = 1'b1;
      n.arb = 1'b1;
      n.berr = 1'b1;
      n.eng = E_IDLE;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
    end

    // Software requests; ignored unless the engine is idle, holding or in its bus free time.
    // A request during our own bus free time keeps the remaining count and waits it out.
    if (wr_hit_tgt && q.en && (q.eng == E_IDLE || q.eng == E_HOLD || q.eng == E_PS)) begin
      n.byte_r = WDATA;
      n.write_done_flag = 1'b0;
      n.read_done_flag = 1'b0;
      n.eng = (q.eng == E_HOLD) ? E_RSL : E_WAIT;
      n.cnt = (q.eng == E_HOLD) ? phase_len(q.baud, LOW_EXTRA) : q.cnt;
    end else if (WR_STB && ADDR == REG_BYTE && q.eng == E_HOLD && !q.rxmode) begin
      // Data byte written while holding after a write.
      n.byte_r = WDATA;
      n.write_done_flag = 1'b0;
      n.bitn = 4'h0;
      n.eng = E_LOW;
      n.cnt = phase_len(q.baud, LOW_EXTRA);
    end else if (WR_STB && ADDR == REG_CTRL_B && q.eng == E_HOLD && WDATA[CB_CMD_LSB +: 2] != CMD_NONE) begin
      n.write_done_flag = 1'b0;
      n.read_done_flag = 1'b0;
      n.cnt = phase_len(q.baud, LOW_EXTRA);
      if (q.rxmode) begin
        // A read command first sends the chosen acknowledge bit.
        n.act = WDATA[CB_CMD_LSB +: 2];
        n.bitn = ACK_BITN;
        n.eng = E_LOW;
      end else if (WDATA[CB_CMD_LSB +: 2] == CMD_STOP) begin
        n.eng = E_PL;
        n.sda_low = 1'b1;
      end else if (WDATA[CB_CMD_LSB +: 2] == CMD_REPSTART) begin
        n.byte_r = q.target;
        n.eng = E_RSL;
      end else begin
        n.write_done_flag = q.write_done_flag;
      end
    end

    if (n.eng == E_HOLD) begin
      n.scl_low = n.write_done_flag || n.read_done_flag;
    end

    if (!n.en) begin
      n.eng = E_IDLE;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
    end

    n.rdata = 8'h00;
    if (RD_STB) begin
      unique case (ADDR)
        REG_CTRL_A: n.rdata = {4'h0, q.tsel, 1'b0, q.en};
        REG_CTRL_B: n.rdata = {5'h00, q.ackact, 2'h0};
        REG_STATUS: n.rdata = {q.read_done_flag, q.write_done_flag, (q.eng == E_HOLD) && (q.write_done_flag || q.read_done_flag), q.ack, q.arb, q.berr,
          (q.en ? mon_if.state : LS_UNKNOWN)};
        REG_RATE: n.rdata = q.baud;
        REG_TARGET: n.rdata = q.target;
        REG_BYTE: n.rdata = q.byte_r;
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // Register the record; reset leaves the bus released and the host disabled.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      q <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, en: 1'b0, tsel: 2'h0, ackact: 1'b0,
        baud: RATE_RESET, target: BYTE_RESET, byte_r: BYTE_RESET, write_done_flag: 1'b0, read_done_flag: 1'b0, ack: 1'b0,
        arb: 1'b0, berr: 1'b0, eng: E_IDLE, cnt: 9'h000, bitn: 4'h0, rxmode: 1'b0, addr_ph: 1'b0,
        act: CMD_NONE, scl_low: 1'b0, sda_low: 1'b0, rdata: 8'h00};
    end else begin
      q <= n;
    end
  end

endmodule

// ===== sim/twu_host_top_properties.sv
// Port-level assertions for the two-wire host engine.
`timescale 1ns/1ps
module twu_host_properties import twu_pkg::*; (
  input wire logic MCLK, // Clock.
  input wire logic RESET_N, // Reset, active low.
  input wire logic [2:0] ADDR, // Index.
  input wire logic [7:0] WDATA, // Write data.
  input wire logic WR_STB, // Write strobe.
  input wire logic RD_STB, // Read strobe.
  input wire logic [7:0] RDATA, // Read data.
  input wire logic SCL_IN, // SCL wire.
  input wire logic SCL_OUT, // SCL value.
  input wire logic SCL_OE_N, // SCL pull.
  input wire logic SDA_IN, // SDA wire.
  input wire logic SDA_OUT, // SDA value.
  input wire logic SDA_OE_N // SDA pull.
);
  logic [7:0] rate_q; // Rate last written.
  logic en_q; // Enable last written.
  logic st_q; // Status read taken last cycle.
  logic [8:0] low_q; // Pull length; saturates so long holds never wrap.
  // Mirror of the settings that the checks need.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      rate_q <= RATE_RESET;
      en_q <= 1'h0;
      st_q <= 1'h0;
      low_q <= 9'h000;
    end else begin
      if (WR_STB && ADDR == REG_RATE) begin
        rate_q <= WDATA;
      end
      if (WR_STB && ADDR == REG_CTRL_A) begin
        en_q <= WDATA[CA_EN_BIT];
      end
      st_q <= RD_STB && ADDR == REG_STATUS;
      low_q <= SCL_OE_N ? 9'h000 : low_q + {8'h00, low_q != 9'h1ff};
    end
  end
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  scl_low_min_a: assert property ($rose(SCL_OE_N) |-> low_q >= {1'h0, rate_q} + LOW_EXTRA)
    else $error("SCL low too short");
  scl_seen_high_a: assert property ($fell(SCL_OE_N) |-> $past(SCL_IN, 1) && $past(SCL_IN, 2) && $past(SCL_IN, 3))
    else $error("SCL pulled before seen high");
  hold_on_flag_a: assert property (st_q && (RDATA[ST_WIF_BIT] || RDATA[ST_RIF_BIT]) && !RDATA[ST_ARB_BIT] |-> !SCL_OE_N)
    else $error("flag set but SCL free");
  stretch_flag_a: assert property (st_q && RDATA[ST_HOLD_BIT] |-> (RDATA[ST_WIF_BIT] || RDATA[ST_RIF_BIT]))
    else $error("stretch without flag");
  flags_apart_a: assert property (st_q |-> !(RDATA[ST_WIF_BIT] && RDATA[ST_RIF_BIT]))
    else $error("both done flags set");
  arb_release_a: assert property (st_q && RDATA[ST_ARB_BIT] && RDATA[1:0] == LS_BUSY |-> SCL_OE_N && SDA_OE_N)
    else $error("lines held after lost arbitration");
  fault_flags_a: assert property (st_q && RDATA[ST_BERR_BIT] |-> RDATA[ST_ARB_BIT] && RDATA[ST_WIF_BIT])
    else $error("bus fault without lost flags");
  enable_unknown_a: assert property ((WR_STB && ADDR == REG_CTRL_A && WDATA[CA_EN_BIT] != en_q) ##1
    (RD_STB && ADDR == REG_STATUS) |=> RDATA[1:0] == LS_UNKNOWN) else $error("state not unknown");
  force_idle_a: assert property ((WR_STB && ADDR == REG_STATUS && WDATA[1:0] == LS_IDLE && en_q) ##1
    (RD_STB && ADDR == REG_STATUS) |=> RDATA[1:0] == LS_IDLE) else $error("idle not forced");
  cover property (st_q && RDATA[ST_WIF_BIT] && !RDATA[ST_ACK_BIT]);
  cover property (st_q && RDATA[ST_ARB_BIT]);
  cover property (st_q && RDATA[ST_RIF_BIT]);
endmodule
bind twu_host_top twu_host_properties u_props (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N));

// ===== sim/twu_client_model.sv
// Behavioural client on the wires: answers one address, returns one byte, stretches SCL.
`timescale 1ns/1ps
module twu_client_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50, // Answered address.
  parameter logic [7:0] TX_BYTE = 8'h5a, // Byte sent on reads.
  parameter int STRETCH_NS = 150 // Extra low time after each SCL fall inside a frame.
) (
  input wire logic scl, // SCL wire.
  input wire logic sda, // SDA wire.
  output logic scl_n, // Low pulls SCL.
  output logic sda_n // Low pulls SDA.
);
  logic act = 1'h0; // Inside a frame.
  logic hit = 1'h0; // Address matched.
  logic [7:0] sh; // Received bits.
  int bitn; // Bit count in frame.
  initial begin
    scl_n = 1'h1;
    sda_n = 1'h1;
  end
  // Start opens a frame; Stop closes it and frees SDA.
  always @(negedge sda) if (scl) begin
    act = 1'h1;
    bitn = 0;
    hit = 1'h0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'h0;
    sda_n = 1'h1;
  end
  // Address bits are taken while SCL is high; each rising edge ends one bit.
  always @(posedge scl) if (act) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
    end
    bitn = bitn + 1;
  end
  always @(negedge scl) if (act) begin
    sda_n = 1'h1;
    if (bitn == 8) begin
      hit = (sh[7:1] == DEV_ADDR);
      sda_n = !hit;
    end else if (hit && sh[0] && bitn >= 9 && bitn <= 16) begin
      sda_n = TX_BYTE[16 - bitn];
    end
    scl_n = 1'h0;
    #(STRETCH_NS);
    scl_n = 1'h1;
  end
endmodule

// ===== sim/twu_host_top_tb.sv
// Self-checking bench for the two-wire host engine with one client.
`timescale 1ns/1ps
module twu_host_top_tb import twu_pkg::*; ;
  logic mclk = 1'h0; // Clock.
  logic rst_n, wr_stb, rd_stb, tb_sda_n; // Reset, strobes, bench SDA pull.
  logic [2:0] addr; // Index.
  logic [7:0] wdata, rdata, d; // Bus data.
  logic scl_oe_n, sda_oe_n, m_scl_n, m_sda_n; // Pulls.
  wire logic scl_w = scl_oe_n & m_scl_n; // Wired-AND with pull-up.
  wire logic sda_w = sda_oe_n & m_sda_n & tb_sda_n; // Wired-AND with pull-up.
  int err_total = 0;
  int check_count = 0;
  int n;
  twu_host_top #(.TOUT_CYC(50)) dut (.MCLK(mclk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .SCL_IN(scl_w), .SCL_OUT(), .SCL_OE_N(scl_oe_n), .SDA_IN(sda_w),
    .SDA_OUT(), .SDA_OE_N(sda_oe_n));
  twu_client_model cli (.scl(scl_w), .sda(sda_w), .scl_n(m_scl_n), .sda_n(m_sda_n));
  initial forever #2.5 mclk = !mclk;
  // Write, then read status at once; returns that status.
  task automatic wr(input logic [2:0] a, input logic [7:0] v, output logic [7:0] s);
    @(posedge mclk) {addr, wdata, wr_stb} <= {a, v, 1'h1};
    @(posedge mclk) {addr, wr_stb, rd_stb} <= {REG_STATUS, 1'h0, 1'h1};
    @(posedge mclk) rd_stb <= 1'h0;
    #1 s = rdata;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] s);
    @(posedge mclk) {addr, rd_stb} <= {a, 1'h1};
    @(posedge mclk) rd_stb <= 1'h0;
    #1 s = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Polls status until the masked value matches, within a bound.
  task automatic poll(input logic [7:0] m, input logic [7:0] v, input int lim);
    n = 0;
    do begin
      rd(REG_STATUS, d);
      n++;
    end while ((d & m) !== v && n < lim);
    chk(d & m, v, "status poll");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    {rst_n, wr_stb, rd_stb, addr, wdata, tb_sda_n} = {1'h0, 1'h0, 1'h0, 3'h0, 8'h00, 1'h1};
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    rd(REG_STATUS, d);
    chk(d, 8'h00, "reset status");
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03, "reset lines");
    wr(3'h6, 8'hff, d);
    rd(3'h6, d);
    chk(d, 8'h00, "unmapped");
    wr(REG_RATE, 8'h0a, d);
    wr(REG_CTRL_A, 8'h01, d);
    chk(d & 8'h03, LS_UNKNOWN, "enable");
    for (int v = 0; v < 4; v += 2) begin
      wr(REG_STATUS, 8'(v + 2), d);
      chk(d & 8'h03, LS_UNKNOWN, "no force");
    end
    wr(REG_STATUS, 8'h01, d);
    chk(d & 8'h03, LS_IDLE, "force idle");
    $display("test setup done");
    wr(REG_TARGET, 8'ha0, d);
    rd(REG_BYTE, d);
    chk(d, 8'ha0, "byte copy");
    while (scl_oe_n) @(posedge mclk);
    n = 0;
    while (!scl_oe_n) @(posedge mclk) n++;
    chk(8'(n), 8'h0a + 8'(LOW_EXTRA), "low period");
    poll(8'h40, 8'h40, 400);
    chk(d, 8'h62, "write ack status");
    chk({7'h00, scl_oe_n}, 8'h00, "hold");
    wr(REG_CTRL_B, {6'h00, CMD_STOP}, d);
    poll(8'h03, LS_IDLE, 200);
    $display("test write address done");
    wr(REG_TARGET, 8'h42, d);
    poll(8'h40, 8'h40, 400);
    chk(d & 8'hf3, 8'h72, "nack status");
    wr(REG_CTRL_B, {6'h00, CMD_STOP}, d);
    poll(8'h03, LS_IDLE, 200);
    $display("test nack done");
    wr(REG_TARGET, 8'ha1, d);
    poll(8'h80, 8'h80, 900);
    chk(d & 8'hf3, 8'ha2, "read status");
    rd(REG_BYTE, d);
    chk(d, 8'h5a, "read byte");
    wr(REG_CTRL_B, 8'h07, d);
    poll(8'h03, LS_IDLE, 200);
    $display("test read done");
    repeat (4) @(posedge mclk) tb_sda_n <= 1'h0;
    wr(REG_TARGET, 8'ha0, d);
    chk(d & 8'h03, LS_BUSY, "external start");
    repeat (100) @(posedge mclk);
    chk({7'h00, scl_oe_n}, 8'h01, "waits for idle");
    @(posedge mclk) tb_sda_n <= 1'h1;
    poll(8'h43, 8'h42, 400);
    wr(REG_CTRL_B, {6'h00, CMD_STOP}, d);
    poll(8'h03, LS_IDLE, 200);
    $display("test busy wait done");
    wr(REG_TARGET, 8'hfe, d);
    while (scl_oe_n) @(posedge mclk);
    @(posedge mclk) tb_sda_n <= 1'h0;
    poll(8'h40, 8'h40, 200);
    chk(d & 8'h4f, 8'h4b, "lost status");
    repeat (50) @(posedge mclk);
    chk({5'h00, scl_oe_n, sda_oe_n, scl_w}, 8'h07, "released");
    rd(REG_STATUS, d);
    chk(d & 8'h03, LS_BUSY, "stays busy");
    @(posedge mclk) tb_sda_n <= 1'h1;
    poll(8'h03, LS_IDLE, 20);
    wr(REG_TARGET, 8'hfe, d);
    while (scl_w) @(posedge mclk);
    while (!scl_w) @(posedge mclk);
    @(posedge mclk) tb_sda_n <= 1'h0;
    poll(8'h4f, 8'h4f, 99);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03, "fault release");
    @(posedge mclk) tb_sda_n <= 1'h1;
    poll(8'h03, LS_IDLE, 20);
    wr(REG_STATUS, 8'h4c, d);
    chk(d & 8'hfc, 8'h00, "flags cleared");
    $display("test arbitration done");
    wr(REG_CTRL_A, 8'h00, d);
    chk(d & 8'h03, LS_UNKNOWN, "disable");
    wr(REG_CTRL_A, 8'h05, d);
    chk(d & 8'h03, LS_UNKNOWN, "enable");
    poll(8'h03, LS_IDLE, 60);
    wr(REG_CTRL_A, 8'h00, d);
    wr(REG_CTRL_A, 8'h01, d);
    @(posedge mclk) tb_sda_n <= 1'h0;
    repeat (20) @(posedge mclk);
    tb_sda_n <= 1'h1;
    poll(8'h03, LS_IDLE, 10);
    $display("test time-out and first stop done");
    wrap_up();
  end
endmodule
